// ---- hw/timer2_pkg.sv ----
package timer2_pkg;
    // Register addresses on the CPU register port.
    localparam logic [15:0] ADDR_COUNTER   = 16'hff20;
    localparam logic [15:0] ADDR_FIRST_CMP = 16'hff22;
    localparam logic [15:0] ADDR_DUAL_ROLE = 16'hff24;
    localparam logic [15:0] ADDR_CAP_ONLY  = 16'hff26;
    localparam logic [15:0] ADDR_TMR_CTRL  = 16'hff30;
    localparam logic [15:0] ADDR_PRESCALE  = 16'hff31;
    localparam logic [15:0] ADDR_OUT_CTRL  = 16'hff32;
    localparam logic [15:0] ADDR_CAPCMP    = 16'hff33;
    localparam logic [15:0] ADDR_EDGE_SEL  = 16'hff34;
    // Reset values.
    localparam logic [7:0]  RST_TMR_CTRL = 8'h00;
    localparam logic [7:0]  RST_PRESCALE = 8'h11;
    localparam logic [7:0]  RST_CAPCMP   = 8'h10;
    localparam logic [7:0]  RST_OUT_CTRL = 8'h00;
    localparam logic [7:0]  RST_EDGE_SEL = 8'h00;
    localparam logic [15:0] RST_CAP_ONLY = 16'h0000;
    // Timer control field positions (upper nibble is this timer).
    localparam int TMC_RUN  = 7;
    localparam int TMC_OVF  = 6;
    localparam int TMC_WIDE = 4;
    // Capture/compare control field positions.
    localparam int CCM_MODE_HI  = 7;
    localparam int CCM_MODE_LO  = 6;
    localparam int CCM_CLR_CAP  = 5;
    localparam int CCM_ONE      = 4;
    localparam int CCM_CLR_DUAL = 3;
    localparam int CCM_ROLE     = 2;
    localparam logic [7:0] CCM_WR_MASK = 8'he0 | 8'h0c;
    localparam logic [7:0] CCM_FIXED   = 8'h10;
    // Output pin control field positions.
    localparam int OPC_EN0  = 4;
    localparam int OPC_LVL0 = 5;
    localparam int OPC_EN1  = 6;
    localparam int OPC_LVL1 = 7;
    // Output modes.
    localparam logic [1:0] MODE_TOGGLE = 2'h0;
    localparam logic [1:0] MODE_PWM1   = 2'h1;
    localparam logic [1:0] MODE_PWM2   = 2'h2;
    localparam logic [1:0] MODE_PPG    = 2'h3;
    // Edge sense codes.
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_NONE = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // Prescaler: code n up to 8 divides the system clock by 8 << n.
    localparam logic [15:0] PS_LOW_DIV  = 16'h0008;
    localparam logic [3:0]  PS_MAX_CODE = 4'h8;
    localparam logic [3:0]  PS_EXT_CODE = 4'hf;
    localparam logic [15:0] MASK_NARROW = 16'h00ff;
    localparam logic [15:0] MASK_WIDE   = 16'hffff;
endpackage : timer2_pkg

// ---- hw/edge_sync_detect.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_sync_detect
    import timer2_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // Pin and sense selection.
    input  wire logic       pinIn,
    input  wire logic [1:0] sense,
    // Detected valid edge.
    output logic            edgePulse
);
    logic s1_reg, s2_reg, s3_reg, level_reg;

    // Three-stage synchroniser; a change counts once stages two and three agree.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pinIn;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Accepted level and edge qualification against the sense setting.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            level_reg <= 1'b0;
            edgePulse <= 1'b0;
        end else begin
            edgePulse <= 1'b0;
            if (s2_reg == s3_reg && s3_reg != level_reg) begin
                level_reg <= s3_reg;
                unique case (sense)
                    EDGE_FALL: edgePulse <= !s3_reg;
                    EDGE_RISE: edgePulse <= s3_reg;
                    EDGE_NONE: edgePulse <= 1'b0;
                    EDGE_BOTH: edgePulse <= 1'b1;
                endcase
            end
        end
    end
endmodule : edge_sync_detect
`default_nettype wire

// ---- hw/timer2_capture_compare.sv ----
// Overview of operation
// - Dual-role register compares or captures per role select; 8 or 16 bits wide.
// - Compare role: dual-role match raises second match request and output control pulse.
// - Compare role with dual clear enabled: match clears the counter.
// - Capture role: dual-role register latches counter on second edge input, holds it.
// - Capture role with dual clear enabled: counter clears after the capture.
// - Capture-only register latches counter on first edge; optional counter clear.
// - Capture-only register is read-only and resets to zero.
// - Dual-role register is read/write in both widths; no reset value.
// - First edge gives an external interrupt request and capture-only trigger.
// - Second edge gives dual-role capture trigger, event count clock, interrupt request.
// - Either compare match can invert a wave output at the selected width.
// - Upper nibble of output pin control steers both wave outputs.
// - Disabled wave output drives the fixed level chosen in output pin control.
// - Output mode field selects PWM or PROGRAMMABLE_PULSE_OUT waveforms instead of toggling.
// - Count clock is a prescaled system clock or the second edge output.
// - Timer control upper nibble steers this counter; register resets to zero.
// - Overflow flag is never cleared by hardware, only by software write.
// - Prescaler select upper nibble picks the count clock; resets to 11h.
// - Capture/compare control at ff33h, resets 10h, documented bit layout.
// - Software sets only the allowed mode combinations; others are prohibited.
// - Modes: 00 toggle both, 01 PWM/toggle, 10 PWM both, 11 PROGRAMMABLE_PULSE_OUT/toggle.
// - A clear source zeroes the counter on the next count clock only.
// - Run bit enables counting; clearing it stops captures and matches.
`timescale 1ns/1ps
`default_nettype none
module timer2_capture_compare
    import timer2_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // CPU register port.
    input  wire logic [15:0] regAddr,
    input  wire logic [15:0] regWrData,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic        regWide,
    output logic [15:0]      regRdData,
    output logic             regRdValid,
    // External edge pins.
    input  wire logic        first_edge_input,
    input  wire logic        second_edge_input,
    // Event requests.
    output logic             firstEdgeIrq,
    output logic             secondEdgeIrq,
    output logic             firstMatchIrq,
    output logic             second_match_irq,
    // Timer output pins.
    output logic             first_wave_out,
    output logic             second_wave_out
);
    logic [7:0]  tmrCtrl_reg, presc_reg, capcmp_reg, outCtrl_reg, edgeSel_reg;
    logic [15:0] counter_reg, firstCmp_reg, dualRole_reg, capOnly_reg;
    logic [10:0] psCnt_reg;
    logic        startPend_reg, clearPend_reg, changed_reg;
    logic        wave0_reg, wave1_reg;
    logic [1:0]  pinVec, edgeVec;
    logic        countRun, wideMode, roleSel, clrCap, clrDual;
    logic [1:0]  outMode;
    logic [15:0] widthMask, psFull, wrVal16;
    logic        psTick, tick, atMax, ovfEvt;
    logic        match0, match1, capTrig1, capTrig2, clearSrc;
    logic        wrTmr, wrCap, wrDual, wrFirst;

    ////////////////////////////////////////////////////////////////////////////
    // Control field decode.
    assign countRun  = tmrCtrl_reg[TMC_RUN];
    assign wideMode  = tmrCtrl_reg[TMC_WIDE];
    assign roleSel   = capcmp_reg[CCM_ROLE];
    assign clrCap    = capcmp_reg[CCM_CLR_CAP];
    assign clrDual   = capcmp_reg[CCM_CLR_DUAL];
    assign outMode   = {capcmp_reg[CCM_MODE_HI], capcmp_reg[CCM_MODE_LO]};
    assign widthMask = wideMode ? MASK_WIDE : MASK_NARROW;
    assign wrTmr     = regWrite && regAddr == ADDR_TMR_CTRL;
    assign wrCap     = regWrite && regAddr == ADDR_CAPCMP;
    assign wrDual    = regWrite && regAddr == ADDR_DUAL_ROLE;
    assign wrFirst   = regWrite && regAddr == ADDR_FIRST_CMP;
    assign wrVal16   = regWide ? regWrData : {8'h00, regWrData[7:0]};

    ////////////////////////////////////////////////////////////////////////////
    // Edge detectors on both pins, each synchronised first.
    assign pinVec = {second_edge_input, first_edge_input};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_edge
            edge_sync_detect u_det (
                .clk_sys   (clk_sys),
                .resetn    (resetn),
                .pinIn     (pinVec[gi]),
                .sense     (edgeSel_reg[2*gi+1 -: 2]),
                .edgePulse (edgeVec[gi])
            );
        end
    endgenerate

    // Edge events become requests and capture triggers.
    assign firstEdgeIrq  = edgeVec[0];
    assign secondEdgeIrq = edgeVec[1];
    assign capTrig1      = edgeVec[0] && countRun;
    assign capTrig2      = edgeVec[1] && countRun && roleSel;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler: code n up to 8 gives one tick every 8 << n system clocks.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            psCnt_reg <= '0;
        end else begin
            psCnt_reg <= psCnt_reg + 11'h1;
        end
    end

    // Count clock selector between prescaler and second edge.
    always_comb begin
        psFull = (PS_LOW_DIV << presc_reg[7:4]) - 16'h1;
        psTick = presc_reg[7:4] <= PS_MAX_CODE
                 && (psCnt_reg & psFull[10:0]) == psFull[10:0];
        tick   = (presc_reg[7:4] == PS_EXT_CODE) ? edgeVec[1] : psTick;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter core.
    assign atMax    = (counter_reg & widthMask) == widthMask;
    assign ovfEvt   = countRun && tick && !startPend_reg && !clearPend_reg && atMax;
    assign clearSrc = (match1 && clrDual && !roleSel)
                    || (capTrig2 && clrDual)
                    || (capTrig1 && clrCap);

    // Counter: zero while stopped, cleared on the count clock after a clear source.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            counter_reg <= '0;
        end else if (!countRun) begin
            counter_reg <= '0;
        end else if (tick) begin
            if (startPend_reg || clearPend_reg || atMax) begin
                counter_reg <= '0;
            end else begin
                counter_reg <= (counter_reg + 16'h1) & widthMask;
            end
        end
    end

    // Pending start and pending clear, each released by a count clock.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            startPend_reg <= 1'b1;
            clearPend_reg <= 1'b0;
        end else begin
            if (!countRun) begin
                startPend_reg <= 1'b1;
            end else if (tick) begin
                startPend_reg <= 1'b0;
            end
            if (!countRun) begin
                clearPend_reg <= 1'b0;
            end else if (clearSrc) begin
                clearPend_reg <= 1'b1;
            end else if (tick) begin
                clearPend_reg <= 1'b0;
            end
        end
    end

    // Compare happens once per new counter value.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            changed_reg <= 1'b0;
        end else begin
            changed_reg <= countRun && tick;
        end
    end

    assign match0 = changed_reg && countRun
                    && (counter_reg & widthMask) == (firstCmp_reg & widthMask);
    assign match1 = changed_reg && countRun && !roleSel
                    && (counter_reg & widthMask) == (dualRole_reg & widthMask);

    // Registered match requests.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            firstMatchIrq    <= 1'b0;
            second_match_irq <= 1'b0;
        end else begin
            firstMatchIrq    <= match0;
            second_match_irq <= match1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer control: software owns every bit, the overflow is only ever set.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            tmrCtrl_reg <= RST_TMR_CTRL;
        end else begin
            if (wrTmr) begin
                tmrCtrl_reg <= regWrData[7:0];
            end
            if (ovfEvt) begin
                tmrCtrl_reg[TMC_OVF] <= 1'b1;
            end
        end
    end

    // Prescaler select, output pin control and edge sense registers.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            presc_reg   <= RST_PRESCALE;
            outCtrl_reg <= RST_OUT_CTRL;
            edgeSel_reg <= RST_EDGE_SEL;
        end else if (regWrite) begin
            if (regAddr == ADDR_PRESCALE) presc_reg <= regWrData[7:0];
            if (regAddr == ADDR_OUT_CTRL) outCtrl_reg <= regWrData[7:0];
            if (regAddr == ADDR_EDGE_SEL) edgeSel_reg <= regWrData[7:0];
        end
    end

    // Capture/compare control; bit 4 reads one and bits 1-0 read zero.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            capcmp_reg <= RST_CAPCMP;
        end else if (wrCap) begin
            capcmp_reg <= (regWrData[7:0] & CCM_WR_MASK) | CCM_FIXED;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Compare values; the dual-role register has no reset value.
    always_ff @(posedge clk_sys) begin
        if (wrFirst) begin
            firstCmp_reg <= wrVal16;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (capTrig2) begin
            dualRole_reg <= counter_reg & widthMask;
        end else if (wrDual) begin
            dualRole_reg <= wrVal16;
        end
    end

    // Capture-only register: hardware loads it, software only reads it.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            capOnly_reg <= RST_CAP_ONLY;
        end else if (capTrig1) begin
            capOnly_reg <= counter_reg & widthMask;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wave generation; a disabled output tracks its fixed level.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wave0_reg <= 1'b0;
        end else if (!outCtrl_reg[OPC_EN0]) begin
            wave0_reg <= outCtrl_reg[OPC_LVL0];
        end else begin
            unique case (outMode)
                MODE_TOGGLE: if (match0) wave0_reg <= !wave0_reg;
                MODE_PWM1, MODE_PWM2: begin
                    if (ovfEvt) wave0_reg <= 1'b1;
                    else if (match0) wave0_reg <= 1'b0;
                end
                MODE_PPG: begin
                    if (match0) wave0_reg <= 1'b1;
                    else if (match1) wave0_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            wave1_reg <= 1'b0;
        end else if (!outCtrl_reg[OPC_EN1]) begin
            wave1_reg <= outCtrl_reg[OPC_LVL1];
        end else if (outMode == MODE_PWM2) begin
            if (ovfEvt) wave1_reg <= 1'b1;
            else if (match1) wave1_reg <= 1'b0;
        end else if (match1) begin
            wave1_reg <= !wave1_reg;
        end
    end

    assign first_wave_out  = wave0_reg;
    assign second_wave_out = wave1_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Register read port, answered one cycle after the strobe.
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            regRdData  <= '0;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRead;
            if (regRead) begin
                unique case (regAddr)
                    ADDR_COUNTER:   regRdData <= counter_reg;
                    ADDR_FIRST_CMP: regRdData <= firstCmp_reg;
                    ADDR_DUAL_ROLE: regRdData <= dualRole_reg;
                    ADDR_CAP_ONLY:  regRdData <= capOnly_reg;
                    ADDR_TMR_CTRL:  regRdData <= {8'h00, tmrCtrl_reg};
                    ADDR_PRESCALE:  regRdData <= {8'h00, presc_reg};
                    ADDR_OUT_CTRL:  regRdData <= {8'h00, outCtrl_reg};
                    ADDR_CAPCMP:    regRdData <= {8'h00, capcmp_reg};
                    ADDR_EDGE_SEL:  regRdData <= {8'h00, edgeSel_reg};
                    default:        regRdData <= '0;
                endcase
                if (!regWide) regRdData[15:8] <= 8'h00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence sCapOnlyClear;
        capTrig1 && clrCap;
    endsequence

    sequence sTickAfter;
        tick && countRun;
    endsequence

    AST_CAPONLY_LATCH: assert property (capTrig1 |=> capOnly_reg == ($past(counter_reg) & $past(widthMask)))
        else $error("capture-only value differs from counter");
    AST_DUAL_LATCH: assert property (capTrig2 |=> dualRole_reg == ($past(counter_reg) & $past(widthMask)))
        else $error("dual-role capture differs from counter");
    AST_CAP_CLEAR: assert property (sCapOnlyClear ##1 sTickAfter |=> counter_reg == 16'h0000)
        else $error("counter not cleared after capture");
    AST_MATCH_REQ: assert property (second_match_irq |-> !$past(roleSel) && $past(counter_reg & widthMask) == $past(dualRole_reg & widthMask))
        else $error("second match request without match");
    AST_CLEAR_HOLD: assert property (clearPend_reg && countRun && !tick |=> counter_reg == $past(counter_reg))
        else $error("counter moved before count clock");
    AST_RUN_OFF: assert property (!countRun |=> counter_reg == 16'h0000 && !match1 && !capTrig1)
        else $error("stopped counter still active");
    AST_OVF_STICKY: assert property (tmrCtrl_reg[TMC_OVF] && !wrTmr |=> tmrCtrl_reg[TMC_OVF])
        else $error("overflow flag lost without write");
    AST_FIXED_LEVEL: assert property (!outCtrl_reg[OPC_EN0] ##1 !outCtrl_reg[OPC_EN0] |-> first_wave_out == $past(outCtrl_reg[OPC_LVL0]))
        else $error("disabled output not at fixed level");
    AST_CAPCMP_FIXED: assert property (capcmp_reg[CCM_ONE] && capcmp_reg[1:0] == 2'h0)
        else $error("capture/compare fixed bits wrong");
endmodule : timer2_capture_compare
`default_nettype wire

// ---- testbench/edge_source_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module edge_source_model (
    // Clock.
    input  wire logic clk_sys,
    // Driven edge pins.
    output logic      firstPin,
    output logic      secondPin
);
    // Pins rest low between pulses, as behind a pull-down.
    initial begin
        firstPin = 1'b0;
        secondPin = 1'b0;
    end

    // Pulses stay five clocks high and low, so no edge is lost by the filter.
    task automatic pulse(input bit which, input int count);
        repeat (count) begin
            @(posedge clk_sys);
            if (which) secondPin <= 1'b1;
            else firstPin <= 1'b1;
            repeat (5) @(posedge clk_sys);
            if (which) secondPin <= 1'b0;
            else firstPin <= 1'b0;
            repeat (5) @(posedge clk_sys);
        end
    endtask : pulse
endmodule : edge_source_model
`default_nettype wire

// ---- testbench/timer2_capture_compare_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer2_capture_compare_tb;
    import timer2_pkg::*;
    logic        clk_sys, resetn, regWrite, regRead, regWide, regRdValid;
    logic [15:0] regAddr, regWrData, regRdData, rdVal, cnt;
    logic        firstPin, secondPin, firstIrq, secondIrq, matchIrq, cmpIrq, waveA, waveB;
    int          bad_count, n_checks, nFirst, nSecond, nMatch, nCmp, n;

    // Clock with a 4 ns period.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    timer2_capture_compare i_dut (
        .clk_sys(clk_sys), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regWide(regWide), .regRdData(regRdData),
        .regRdValid(regRdValid), .first_edge_input(firstPin), .second_edge_input(secondPin),
        .firstEdgeIrq(firstIrq), .secondEdgeIrq(secondIrq), .firstMatchIrq(cmpIrq),
        .second_match_irq(matchIrq), .first_wave_out(waveA), .second_wave_out(waveB));
    edge_source_model i_src (.clk_sys(clk_sys), .firstPin(firstPin), .secondPin(secondPin));

    // Counts the one-cycle event pulses.
    always @(posedge clk_sys) begin
        if (firstIrq === 1'b1) nFirst++;
        if (secondIrq === 1'b1) nSecond++;
        if (matchIrq === 1'b1) nMatch++;
        if (cmpIrq === 1'b1) nCmp++;
    end

    // Compares one value and reports a difference at once.
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One register write, strobe held for one clock.
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWide <= w;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : wr

    // One register read; data is taken while the valid pulse stands.
    task automatic rd(input logic [15:0] a, input logic w);
        @(posedge clk_sys);
        regAddr <= a;
        regWide <= w;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(negedge clk_sys);
        check("read valid", {15'h0000, regRdValid}, 16'h0001);
        rdVal = regRdData;
    endtask : rd

    // Prints the counts and the verdict, then stops the run.
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // Cuts a hang short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        end_of_test();
    end

    // Main sequence of scenarios.
    initial begin
        {resetn, regWrite, regRead, regWide, regAddr, regWrData} = '0;
        {bad_count, n_checks, nFirst, nSecond, nMatch} = '0;
        void'($urandom(32'h3bf5));
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(ADDR_CAPCMP, 1'b0);
        check("capcmp reset", rdVal, {8'h00, RST_CAPCMP});
        rd(ADDR_PRESCALE, 1'b0);
        check("prescale reset", rdVal, {8'h00, RST_PRESCALE});
        rd(ADDR_TMR_CTRL, 1'b0);
        check("ctrl reset", rdVal, {8'h00, RST_TMR_CTRL});
        rd(ADDR_CAP_ONLY, 1'b1);
        check("cap reset", rdVal, RST_CAP_ONLY);
        // Allowed PROGRAMMABLE_PULSE_OUT combination; bit 4 written low and bits 1-0 written high.
        wr(ADDR_CAPCMP, 16'h00cb, 1'b0);
        rd(ADDR_CAPCMP, 1'b0);
        check("capcmp fixed bits", rdVal, 16'h00d8);
        wr(ADDR_CAP_ONLY, 16'h1234, 1'b1);
        rd(ADDR_CAP_ONLY, 1'b1);
        check("cap read only", rdVal, 16'h0000);
        rd(16'hff3f, 1'b1);
        check("unmapped", rdVal, 16'h0000);
        // Dual-role register in both widths with random contents.
        repeat (3) begin
            cnt = 16'($urandom);
            wr(ADDR_DUAL_ROLE, cnt, 1'b1);
            rd(ADDR_DUAL_ROLE, 1'b1);
            check("dual wide", rdVal, cnt);
            wr(ADDR_DUAL_ROLE, cnt, 1'b0);
            rd(ADDR_DUAL_ROLE, 1'b1);
            check("dual narrow", rdVal, {8'h00, cnt[7:0]});
        end
        // External count clock, rising edges on both pins, 16-bit run, capture clear on.
        wr(ADDR_PRESCALE, 16'h00f1, 1'b0);
        wr(ADDR_EDGE_SEL, 16'h0005, 1'b0);
        wr(ADDR_CAPCMP, 16'h0030, 1'b0);
        wr(ADDR_TMR_CTRL, 16'h0090, 1'b0);
        n = 2 + $urandom % 8;
        {nFirst, nSecond} = '0;
        i_src.pulse(1'b1, n);
        i_src.pulse(1'b0, 1);
        rd(ADDR_CAP_ONLY, 1'b1);
        check("cap value", rdVal, 16'(n - 1));
        check("second edges", 16'(nSecond), 16'(n));
        check("first edges", 16'(nFirst), 16'h0001);
        // Compare match at 3 with clear and toggle on the second output.
        wr(ADDR_TMR_CTRL, 16'h0000, 1'b0);
        wr(ADDR_CAPCMP, 16'h0008, 1'b0);
        wr(ADDR_DUAL_ROLE, 16'h0003, 1'b1);
        wr(ADDR_FIRST_CMP, 16'h0002, 1'b1);
        wr(ADDR_OUT_CTRL, 16'h0040, 1'b0);
        wr(ADDR_TMR_CTRL, 16'h0090, 1'b0);
        nMatch = 0;
        nCmp = 0;
        i_src.pulse(1'b1, 5);
        rd(ADDR_COUNTER, 1'b1);
        check("cleared count", rdVal, 16'h0000);
        check("matches", 16'(nMatch), 16'h0001);
        check("first matches", 16'(nCmp), 16'h0001);
        check("toggle out", {15'h0000, waveB}, 16'h0001);
        // Capture role: value taken on the second pin, held across a first-pin edge.
        wr(ADDR_CAPCMP, 16'h0004, 1'b0);
        i_src.pulse(1'b1, 2);
        rd(ADDR_COUNTER, 1'b1);
        cnt = rdVal;
        rd(ADDR_DUAL_ROLE, 1'b1);
        check("dual capture", 16'((rdVal === cnt) || (rdVal === cnt - 16'h0001)), 16'h0001);
        cnt = rdVal;
        i_src.pulse(1'b0, 1);
        rd(ADDR_DUAL_ROLE, 1'b1);
        check("dual held", rdVal, cnt);
        // Disabled outputs drive their fixed levels.
        wr(ADDR_OUT_CTRL, 16'h00a0, 1'b0);
        repeat (3) @(negedge clk_sys);
        check("fixed levels", {14'h0000, waveA, waveB}, 16'h0003);
        // Eight-bit wrap sets the overflow flag; only a write clears it.
        wr(ADDR_TMR_CTRL, 16'h0000, 1'b0);
        wr(ADDR_TMR_CTRL, 16'h0080, 1'b0);
        i_src.pulse(1'b1, 257);
        rd(ADDR_TMR_CTRL, 1'b0);
        check("overflow set", rdVal, 16'h00c0);
        wr(ADDR_TMR_CTRL, 16'h0080, 1'b0);
        rd(ADDR_TMR_CTRL, 1'b0);
        check("overflow cleared", rdVal, 16'h0080);
        wr(ADDR_TMR_CTRL, 16'h0000, 1'b0);
        rd(ADDR_COUNTER, 1'b1);
        check("stopped count", rdVal, 16'h0000);
        end_of_test();
    end
endmodule : timer2_capture_compare_tb
`default_nettype wire
